// [design/gpio_port_pkg.sv]
/*
 * Constants shared by the port pin block: register byte offsets, field
 * positions, reset values and bus response codes.
 * Assumes a 32-bit AXI4-Lite register bus with byte addressing.
 */
package gpio_port_pkg;

   // ----------------------------------------------------------------
   // Geometry
   // ----------------------------------------------------------------
   localparam int DEF_PINS = 6;          // Pins on one port
   localparam int ADDR_W = 8;            // Register bus address width
   localparam int DATA_W = 32;           // Register bus data width
   localparam int STRB_W = DATA_W / 8;   // Byte lanes

   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFF_INPUT = 8'h00;   // port_input_reg
   localparam logic [ADDR_W-1:0] OFF_DIR = 8'h04;     // port_dir_reg
   localparam logic [ADDR_W-1:0] OFF_OUT = 8'h08;     // port_out_reg
   localparam logic [ADDR_W-1:0] OFF_MCU = 8'h0c;     // mcu_control_reg
   localparam logic [ADDR_W-1:0] OFF_DIR_SET = 8'h10; // Set dir bits
   localparam logic [ADDR_W-1:0] OFF_DIR_CLR = 8'h14; // Clear dir bits
   localparam logic [ADDR_W-1:0] OFF_OUT_SET = 8'h18; // Set out bits
   localparam logic [ADDR_W-1:0] OFF_OUT_CLR = 8'h1c; // Clear out bits

   // ----------------------------------------------------------------
   // Fields, reset values and response codes
   // ----------------------------------------------------------------
   localparam int PUD_BIT = 0;              // global_pullup_off position
   localparam logic PUD_RESET = 1'b0;       // Pull-ups allowed after reset
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : gpio_port_pkg

// [design/gpio_reg_if.sv]
/*
 * Carrier between the bus slave and the register file: one write
 * strobe with its address and data, and a read address with its data.
 * Assumes both ends sit on the same clock.
 */
`timescale 1ns/10ps
`default_nettype none

interface gpio_reg_if;
   import gpio_port_pkg::*;
   logic wr_en;                    // One-cycle write strobe
   logic [ADDR_W-1:0] wr_addr;     // Write byte address
   logic [DATA_W-1:0] wr_data;     // Write data
   logic [STRB_W-1:0] wr_strb;     // Write byte enables
   logic wr_ok;                    // Write address is mapped
   logic [ADDR_W-1:0] rd_addr;     // Read byte address
   logic [DATA_W-1:0] rd_data;     // Read data for rd_addr
   logic rd_ok;                    // Read address is mapped

   modport bus (output wr_en, wr_addr, wr_data, wr_strb, rd_addr,
                input wr_ok, rd_data, rd_ok);
   modport regs (input wr_en, wr_addr, wr_data, wr_strb, rd_addr,
                 output wr_ok, rd_data, rd_ok);
endinterface : gpio_reg_if

`default_nettype wire

// [design/axil_slave.sv]
/*
 * AXI4-Lite slave: takes write address and data in either order, emits
 * one write strobe, answers reads one cycle after the address.
 * Assumes the register file decodes combinationally on the carrier.
 */
`timescale 1ns/10ps
`default_nettype none

module axil_slave
   import gpio_port_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [DATA_W-1:0] wdata,
   input wire logic [STRB_W-1:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [DATA_W-1:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   gpio_reg_if.bus regs
);

   // ----------------------------------------------------------------
   // Write channels
   // ----------------------------------------------------------------
   logic [ADDR_W-1:0] aw_q;    // Held write address
   logic [DATA_W-1:0] w_q;     // Held write data
   logic [STRB_W-1:0] s_q;     // Held byte enables

   // Both halves held and no answer pending: perform the write
   assign regs.wr_en = ~awready & ~wready & ~bvalid & ce;
   assign regs.wr_addr = aw_q;
   assign regs.wr_data = w_q;
   assign regs.wr_strb = s_q;
   assign regs.rd_addr = araddr;

   // Address and data capture; ready drops while a half is held
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready <= 1'b1;
         wready <= 1'b1;
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
         aw_q <= '0;
         w_q <= '0;
         s_q <= '0;
      end else if (ce) begin
         if (awvalid && awready) begin
            aw_q <= awaddr;
            awready <= 1'b0;
         end
         if (wvalid && wready) begin
            w_q <= wdata;
            s_q <= wstrb;
            wready <= 1'b0;
         end
         if (regs.wr_en) begin
            // Unmapped address answers SLVERR, nothing stored
            bvalid <= 1'b1;
            bresp <= regs.wr_ok ? RESP_OKAY : RESP_SLVERR;
         end
         if (bvalid && bready) begin
            bvalid <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Read channels
   // ----------------------------------------------------------------
   // Data are registered at the address handshake
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b1;
         rvalid <= 1'b0;
         rdata <= '0;
         rresp <= RESP_OKAY;
      end else if (ce) begin
         if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= regs.rd_ok ? regs.rd_data : '0;
            rresp <= regs.rd_ok ? RESP_OKAY : RESP_SLVERR;
         end else if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
         end
      end
   end

endmodule : axil_slave

`default_nettype wire

// [design/pin_sync.sv]
/*
 * Two-stage pad synchroniser per pin: a falling-edge capture stage that
 * acts as the latch closing on the low phase, then a rising-edge stage.
 * Assumes pad levels are already clamped where required.
 */
`timescale 1ns/10ps
`default_nettype none

module pin_sync #(
   parameter int NUM_PINS = 6
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic [NUM_PINS-1:0] din,
   output logic [NUM_PINS-1:0] dout
);

   logic [NUM_PINS-1:0] latch_q;   // Held at the falling edge

   // ----------------------------------------------------------------
   // Per-pin stages
   // ----------------------------------------------------------------
   for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
      // First stage samples the pad at the falling edge, holds it until the next falling edge
      always_ff @(negedge aclk) begin
         if (!aresetn) begin
            latch_q[i] <= 1'b0;
         end else if (ce) begin
            latch_q[i] <= din[i];
         end
      end
      // Second stage read only here, metastability settles half a cycle
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            dout[i] <= 1'b0;
         end else if (ce) begin
            dout[i] <= latch_q[i];
         end
      end
   end

endmodule : pin_sync

`default_nettype wire

// [design/bidir_port_pin_control.sv]
/*
 * One general-purpose port: direction, output/pull-up and input bits per
 * pin, toggling by input-register writes, global pull-up disable, pad
 * synchroniser and power-down input clamp, behind an AXI4-Lite slave.
 * Assumes pads are joined outside from pad_out, pad_oe, pad_pullup_en.
 */
// Our own choices: the AXI4-Lite interface to the registers and the placing of the registers.
// Overview of operation
// - Three bits per pin, three registers
// - Direction one means output, zero input
// - Input with out bit one: pull-up
// - Output drives pad from out bit
// - Reset tri-states pins without a clock
// - Writing one to input bit toggles out
// - Global disable suppresses every pull-up
// - Pad readable through latch plus register
// - Pad edge visible after half to 1.5
// - Written value readable after two periods
// - Power-down clamps digital input to ground
// - Enabled external interrupt pins skip clamp
// - Clamp release edge sets interrupt flag
// - Pull-ups off while reset asserted
// - Input register read-only, others read/write
`timescale 1ns/10ps
`default_nettype none

module bidir_port_pin_control
   import gpio_port_pkg::*;
#(
   parameter int NUM_PINS = DEF_PINS
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [DATA_W-1:0] wdata,
   input wire logic [STRB_W-1:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [DATA_W-1:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic [NUM_PINS-1:0] pad_in,
   output logic [NUM_PINS-1:0] pad_out,
   output logic [NUM_PINS-1:0] pad_oe,
   output logic [NUM_PINS-1:0] pad_pullup_en,
   input wire logic sleep_powerdown,
   input wire logic [NUM_PINS-1:0] ext_irq_enable,
   output logic [NUM_PINS-1:0] ext_din
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   gpio_reg_if regs ();               // Bus-to-register carrier
   logic [NUM_PINS-1:0] pin_dir_bit;        // port_dir_reg
   logic [NUM_PINS-1:0] pin_out_pullup_bit; // port_out_reg
   logic [NUM_PINS-1:0] pin_input_bit;      // port_input_reg contents
   logic global_pullup_off;                 // mcu_control_reg field
   logic [NUM_PINS-1:0] clamped_in;         // Pad after sleep clamp
   logic [NUM_PINS-1:0] wr_bits;            // Low lane of write data
   logic lane0;                             // Low byte lane enabled
   logic wr_input;                          // Strobes per register
   logic wr_dir;
   logic wr_out;
   logic wr_mcu;
   logic wr_dir_set;
   logic wr_dir_clr;
   logic wr_out_set;
   logic wr_out_clr;
   logic [NUM_PINS-1:0] next_dir;           // Next direction bits
   logic [NUM_PINS-1:0] next_out;           // Next output bits

   // ----------------------------------------------------------------
   // Bus slave
   // ----------------------------------------------------------------
   axil_slave u_bus (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .awaddr(awaddr),
      .awvalid(awvalid),
      .awready(awready),
      .wdata(wdata),
      .wstrb(wstrb),
      .wvalid(wvalid),
      .wready(wready),
      .bresp(bresp),
      .bvalid(bvalid),
      .bready(bready),
      .araddr(araddr),
      .arvalid(arvalid),
      .arready(arready),
      .rdata(rdata),
      .rresp(rresp),
      .rvalid(rvalid),
      .rready(rready),
      .regs(regs)
   );

   // ----------------------------------------------------------------
   // Write decode
   // ----------------------------------------------------------------
   // Port bits sit in the low byte; other lanes are ignored
   assign lane0 = regs.wr_strb[0];
   assign wr_bits = regs.wr_data[NUM_PINS-1:0];

   always_comb begin
      wr_input = 1'b0;
      wr_dir = 1'b0;
      wr_out = 1'b0;
      wr_mcu = 1'b0;
      wr_dir_set = 1'b0;
      wr_dir_clr = 1'b0;
      wr_out_set = 1'b0;
      wr_out_clr = 1'b0;
      regs.wr_ok = 1'b1;
      unique case (regs.wr_addr)
         OFF_INPUT: wr_input = regs.wr_en & lane0;
         OFF_DIR: wr_dir = regs.wr_en & lane0;
         OFF_OUT: wr_out = regs.wr_en & lane0;
         OFF_MCU: wr_mcu = regs.wr_en & lane0;
         OFF_DIR_SET: wr_dir_set = regs.wr_en & lane0;
         OFF_DIR_CLR: wr_dir_clr = regs.wr_en & lane0;
         OFF_OUT_SET: wr_out_set = regs.wr_en & lane0;
         OFF_OUT_CLR: wr_out_clr = regs.wr_en & lane0;
         // Unmapped: refused with an error answer
         default: regs.wr_ok = 1'b0;
      endcase
   end

   // ----------------------------------------------------------------
   // Next register values
   // ----------------------------------------------------------------
   // Whole-word writes replace; set/clear aliases touch only ones
   always_comb begin
      next_dir = pin_dir_bit;
      next_out = pin_out_pullup_bit;
      if (wr_dir) begin
         next_dir = wr_bits;
      end
      if (wr_dir_set) begin
         next_dir = pin_dir_bit | wr_bits;
      end
      if (wr_dir_clr) begin
         next_dir = pin_dir_bit & ~wr_bits;
      end
      if (wr_out) begin
         next_out = wr_bits;
      end
      if (wr_out_set) begin
         next_out = pin_out_pullup_bit | wr_bits;
      end
      if (wr_out_clr) begin
         next_out = pin_out_pullup_bit & ~wr_bits;
      end
      // a one toggles out bit, direction ignored
      if (wr_input) begin
         next_out = pin_out_pullup_bit ^ wr_bits;
      end
   end

   // ----------------------------------------------------------------
   // Control registers
   // ----------------------------------------------------------------
   // direction and output bits reset to zero
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_dir_bit <= '0;
         pin_out_pullup_bit <= '0;
      end else if (ce) begin
         pin_dir_bit <= next_dir;
         pin_out_pullup_bit <= next_out;
      end
   end

   // Global pull-up disable, shared by every pin of this port
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         global_pullup_off <= PUD_RESET;
      end else if (ce && wr_mcu) begin
         global_pullup_off <= regs.wr_data[PUD_BIT];
      end
   end

   // ----------------------------------------------------------------
   // Pad drivers
   // ----------------------------------------------------------------
   // Cleared the moment reset falls, even with the clock stopped;
   // the pads are the only state that must not wait for an edge.
   // immediate tri-state on reset
   always_ff @(posedge aclk or negedge aresetn) begin
      if (!aresetn) begin
         pad_oe <= '0;
         pad_out <= '0;
         pad_pullup_en <= '0;
      end else if (ce) begin
         pad_oe <= pin_dir_bit;
         // driven level follows the out bit
         pad_out <= pin_out_pullup_bit;
         // pull-up only on inputs with out bit one
         pad_pullup_en <= ~pin_dir_bit & pin_out_pullup_bit &
                          {NUM_PINS{~global_pullup_off}};
      end
   end

   // ----------------------------------------------------------------
   // Input path
   // ----------------------------------------------------------------
   // power-down forces input to ground
   // enabled external interrupts keep their input
   assign clamped_in = pad_in &
                       ~({NUM_PINS{sleep_powerdown}} & ~ext_irq_enable);

   // delay half to one and a half periods
   pin_sync #(
      .NUM_PINS(NUM_PINS)
   ) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .din(clamped_in),
      .dout(pin_input_bit)
   );

   // Synchronised, clamped level for the external interrupt logic;
   // a pin without ext_irq_enable held high through power-down rises here at wake-up.
   // clamp release shows as an edge
   assign ext_din = pin_input_bit;

   // ----------------------------------------------------------------
   // Read decode
   // ----------------------------------------------------------------
   // input register is read-only storage
   // pad read back two periods after written
   always_comb begin
      regs.rd_data = '0;
      regs.rd_ok = 1'b1;
      unique case (regs.rd_addr)
         OFF_INPUT: regs.rd_data[NUM_PINS-1:0] = pin_input_bit;
         OFF_DIR: regs.rd_data[NUM_PINS-1:0] = pin_dir_bit;
         OFF_OUT: regs.rd_data[NUM_PINS-1:0] = pin_out_pullup_bit;
         OFF_MCU: regs.rd_data[PUD_BIT] = global_pullup_off;
         // Set/clear aliases are write-only and read as zero
         OFF_DIR_SET, OFF_DIR_CLR, OFF_OUT_SET, OFF_OUT_CLR:
            regs.rd_ok = 1'b1;
         default: regs.rd_ok = 1'b0;
      endcase
   end

endmodule : bidir_port_pin_control

`default_nettype wire

// [testbench/bidir_port_assertions.sv]
/* Concurrent checks on the port pin block, seen from its ports.
   Assumes one clock domain; the bus rests while ce is low. */
`timescale 1ns/10ps
`default_nettype none

module bidir_port_checker
   import gpio_port_pkg::*;
#(
   parameter int NUM_PINS = DEF_PINS
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic [DATA_W-1:0] rdata,
   input wire logic [NUM_PINS-1:0] pad_in,
   input wire logic [NUM_PINS-1:0] pad_oe,
   input wire logic [NUM_PINS-1:0] pad_pullup_en,
   input wire logic sleep_powerdown,
   input wire logic [NUM_PINS-1:0] ext_irq_enable,
   input wire logic [NUM_PINS-1:0] ext_din
);
   // ----------
   // Helpers
   // ----------
   // Pad level after the power-down clamp
   logic [NUM_PINS-1:0] clamped;
   assign clamped = pad_in & ~({NUM_PINS{sleep_powerdown}} & ~ext_irq_enable);

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // ----------
   // Assertions
   // ----------
   // Reset itself is the cause here, so it cannot also disable the check
   a_reset_tristate: assert property (disable iff (1'b0)
      !aresetn |=> pad_oe == '0 && pad_pullup_en == '0)
      else $error("pads not released during reset");
   a_pullup_vs_dir: assert property (
      (pad_pullup_en & pad_oe) == '0)
      else $error("pull-up on a driven pin");
   a_read_answer: assert property (
      arvalid && arready |=> rvalid)
      else $error("read answer late");
   a_read_hold: assert property (
      rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read answer dropped");
   a_write_hold: assert property (
      bvalid && !bready |=> bvalid)
      else $error("write answer dropped");
   a_write_answer: assert property (
      awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
      else $error("write answer late");
   // Falling-edge stage then rising-edge stage: one sample behind
   a_sync_delay: assert property (
      $past(ce) && $past(aresetn) && $past(aresetn, 2) |->
         ext_din == $past(clamped))
      else $error("synchronised input wrong");
   a_pads_by_write: assert property (
      !$stable(pad_oe) |-> bvalid || $past(bvalid))
      else $error("direction moved without a write");

   c_write_done: cover property (bvalid && bready);
   c_read_stall: cover property (rvalid && !rready);
   c_clamp_on: cover property (sleep_powerdown && ext_din != '0);
endmodule : bidir_port_checker

bind bidir_port_pin_control bidir_port_checker #(.NUM_PINS(NUM_PINS)) chk (
   .aclk, .aresetn, .ce, .awvalid, .awready, .wvalid, .wready, .bvalid,
   .bready, .arvalid, .arready, .rvalid, .rready, .rdata, .pad_in,
   .pad_oe, .pad_pullup_en, .sleep_powerdown, .ext_irq_enable, .ext_din);

`default_nettype wire

// [testbench/pad_board.sv]
/* Board seen by the pads: the pin's own driver, an external driver,
   the pull-up, and a floating level that flips every cycle.
   Assumes the bench drives ext_drv and ext_val. */
`timescale 1ns/10ps
`default_nettype none

module pad_board #(
   parameter int NUM_PINS = 6
) (
   input wire logic aclk,
   input wire logic [NUM_PINS-1:0] pad_out,
   input wire logic [NUM_PINS-1:0] pad_oe,
   input wire logic [NUM_PINS-1:0] pad_pullup_en,
   input wire logic [NUM_PINS-1:0] ext_drv,
   input wire logic [NUM_PINS-1:0] ext_val,
   output logic [NUM_PINS-1:0] pad_in
);
   // Undriven pins: no stale value, so a pattern that keeps flipping
   logic [NUM_PINS-1:0] flt = '0;
   always @(posedge aclk) begin
      flt <= ~flt;
   end
   // Own driver wins, then the external one, then pull-up or float
   assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_drv & ext_val) |
      (~pad_oe & ~ext_drv & (pad_pullup_en | flt));
endmodule : pad_board

`default_nettype wire

// [testbench/bidir_port_pin_control_tb_top.sv]
/* Self-checking bench: AXI4-Lite master tasks, board model on pads,
   random register traffic with corner cases.
   Assumes a 100 MHz clock and synchronous active-low reset. */
`timescale 1ns/10ps
`default_nettype none

module bidir_port_pin_control_tb_top;
   import gpio_port_pkg::*;
   localparam int N = DEF_PINS;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic ce = 1'b1; // Dropped once, with the bus at rest
   logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0, sleep_powerdown = 1'b0;
   logic [DATA_W-1:0] wdata = '0, rdata, d;
   logic [STRB_W-1:0] wstrb = '0;
   logic awready, wready, bvalid, arready, rvalid, pud_m;
   logic [1:0] bresp, rresp;
   logic [N-1:0] pad_in, pad_out, pad_oe, pad_pullup_en, ext_din;
   logic [N-1:0] ext_irq_enable = '0, ext_drv = '0, ext_val = '0;
   logic [N-1:0] dir_m, out_m, m, pu;
   int fails = 0, total_checks = 0, seed = 14, it;

   always #5 aclk = ~aclk;

   bidir_port_pin_control #(.NUM_PINS(N)) uut (.aclk, .aresetn, .ce,
      .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
      .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
      .rresp, .rvalid, .rready, .pad_in, .pad_out, .pad_oe,
      .pad_pullup_en, .sleep_powerdown, .ext_irq_enable, .ext_din);

   pad_board #(.NUM_PINS(N)) board (.aclk, .pad_out, .pad_oe,
      .pad_pullup_en, .ext_drv, .ext_val, .pad_in);

   // ----------
   // Expectations
   // ----------
   function automatic logic [N-1:0] exp_level(input logic [N-1:0] dr,
         input logic [N-1:0] ou, input logic [N-1:0] p);
      return (dr & ou) | (~dr & ext_drv & ext_val) | (~dr & ~ext_drv & p);
   endfunction : exp_level

   // ----------
   // Checks, verdict and bus tasks
   // ----------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : tally_and_finish

   // Starts at a rising edge; handshakes are judged at the falling edge
   // because readies only move on rising edges
   task automatic axi_wr(input logic [ADDR_W-1:0] a,
         input logic [DATA_W-1:0] dt, input logic [STRB_W-1:0] s,
         input logic [1:0] er);
      logic ta, tw, tb;
      int n, st;
      st = $unsigned($random(seed)) % 3;
      awaddr <= a;
      wdata <= dt;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      tb = 1'b0;
      for (n = 0; n < 100 && !tb; n++) begin
         @(negedge aclk);
         ta = awvalid && awready;
         tw = wvalid && wready;
         tb = bvalid && bready;
         if (tb) check(bresp, er);
         @(posedge aclk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         bready <= !tb && n >= st;
      end
      @(posedge aclk);
      if (!tb) fails++;
      if (!tb) tally_and_finish;
   endtask : axi_wr

   task automatic axi_rd(input logic [ADDR_W-1:0] a,
         input logic [DATA_W-1:0] ed, input logic [DATA_W-1:0] mk,
         input logic [1:0] er);
      logic ta, tr;
      int n, st;
      st = $unsigned($random(seed)) % 3;
      araddr <= a;
      arvalid <= 1'b1;
      tr = 1'b0;
      for (n = 0; n < 100 && !tr; n++) begin
         @(negedge aclk);
         ta = arvalid && arready;
         tr = rvalid && rready;
         if (tr) check(rdata & mk, ed & mk);
         if (tr) check(rresp, er);
         @(posedge aclk);
         if (ta) arvalid <= 1'b0;
         rready <= !tr && n >= st;
      end
      @(posedge aclk);
      if (!tr) fails++;
      if (!tr) tally_and_finish;
   endtask : axi_rd

   // Lets pads and synchroniser land, ends on a falling edge
   task automatic settle;
      repeat (3) @(posedge aclk);
      @(negedge aclk);
   endtask : settle

   initial begin
      #900000;
      fails++;
      tally_and_finish;
   end

   // ----------
   // Main sequence
   // ----------
   initial begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      @(negedge aclk);
      check(pad_oe | pad_pullup_en, 0);
      @(posedge aclk);
      axi_rd(OFF_DIR, 0, '1, RESP_OKAY);
      axi_rd(OFF_OUT, 0, '1, RESP_OKAY);
      axi_rd(OFF_MCU, 0, '1, RESP_OKAY);
      // One field per write, so no pin jumps 00-11 or 01-10 in one step
      for (it = 0; it < 12; it++) begin
         d = $random(seed);
         out_m = d[N-1:0];
         axi_wr(OFF_OUT, d, 4'hf, RESP_OKAY);
         d = $random(seed);
         dir_m = d[N-1:0];
         axi_wr(OFF_DIR, d, 4'hf, RESP_OKAY);
         d = $random(seed);
         pud_m = d[PUD_BIT];
         axi_wr(OFF_MCU, d, 4'hf, RESP_OKAY);
         d = $random(seed);
         out_m = out_m ^ d[N-1:0];
         axi_wr(OFF_INPUT, d, 4'hf, RESP_OKAY);
         d = $random(seed);
         m = d[N-1:0];
         dir_m = it[0] ? dir_m | m : dir_m & ~m;
         axi_wr(it[0] ? OFF_DIR_SET : OFF_DIR_CLR, d, 4'hf, RESP_OKAY);
         d = $random(seed);
         m = d[N-1:0];
         out_m = it[0] ? out_m & ~m : out_m | m;
         axi_wr(it[0] ? OFF_OUT_CLR : OFF_OUT_SET, d, 4'hf, RESP_OKAY);
         d = $random(seed);
         ext_drv <= d[N-1:0];
         ext_val <= d[2*N-1:N];
         settle;
         pu = ~dir_m & out_m & {N{~pud_m}};
         check(pad_oe, dir_m);
         check(pad_out & dir_m, out_m & dir_m);
         check(pad_pullup_en, pu);
         @(posedge aclk);
         axi_rd(OFF_DIR, dir_m, '1, RESP_OKAY);
         axi_rd(OFF_OUT, out_m, '1, RESP_OKAY);
         // Read back only after the synchroniser delay has passed
         axi_rd(OFF_INPUT, exp_level(dir_m, out_m, pu),
            {{(DATA_W-N){1'b1}}, dir_m | ext_drv | pu}, RESP_OKAY);
      end
      axi_wr(8'h20, '1, 4'hf, RESP_SLVERR);
      axi_rd(8'h24, 0, '1, RESP_SLVERR);
      axi_wr(OFF_DIR, '1, 4'he, RESP_OKAY);
      axi_rd(OFF_DIR, dir_m, '1, RESP_OKAY);
      axi_wr(OFF_MCU, 0, 4'hf, RESP_OKAY);
      axi_wr(OFF_OUT, 32'h3f, 4'hf, RESP_OKAY);
      axi_wr(OFF_DIR, 32'h0f, 4'hf, RESP_OKAY);
      settle;
      check(pad_pullup_en, 6'h30);
      @(posedge aclk);
      aresetn <= 1'b0;
      #1;
      check(pad_oe, 0);
      check(pad_pullup_en, 0);
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      axi_rd(OFF_DIR, 0, '1, RESP_OKAY);
      axi_wr(OFF_MCU, 1, 4'hf, RESP_OKAY);
      d = $random(seed);
      ext_drv <= '1;
      ext_val <= '1;
      ext_irq_enable <= d[N-1:0];
      sleep_powerdown <= 1'b1;
      settle;
      check(ext_din, ext_irq_enable);
      @(posedge aclk);
      axi_rd(OFF_INPUT, ext_irq_enable, '1, RESP_OKAY);
      sleep_powerdown <= 1'b0;
      settle;
      check(ext_din, {N{1'b1}});
      // Synchroniser frozen while ce is low, catches up once it returns
      @(posedge aclk);
      ce <= 1'b0;
      ext_val <= '0;
      settle;
      check(ext_din, {N{1'b1}});
      @(posedge aclk);
      ce <= 1'b1;
      settle;
      check(ext_din, 0);
      tally_and_finish;
   end
endmodule : bidir_port_pin_control_tb_top

`default_nettype wire
